// ---- core/burst_order.sv ----
// Shared constants for the mode register and burst order logic, and the
// column order generator for one beat of a burst.
// Assumes one clock domain; the generator is purely combinational.

package ddr_mode_pkg;
	// Mode register 0 field positions.
	localparam int MR0_BL_LO    = 0;
	localparam int MR0_BL_HI    = 1;
	localparam int MR0_BT       = 3;
	localparam int MR0_DLL_RST  = 8;
	localparam int MR0_WR_LO    = 9;
	localparam int MR0_WR_HI    = 11;
	localparam int MR0_PPD      = 12;
	// Mode register 1 field positions.
	localparam int MR1_DLL_DIS  = 0;
	localparam int MR1_DIC_A    = 1;
	localparam int MR1_RTT_A    = 2;
	localparam int MR1_AL_LO    = 3;
	localparam int MR1_AL_HI    = 4;
	localparam int MR1_DIC_B    = 5;
	localparam int MR1_RTT_B    = 6;
	localparam int MR1_WLVL     = 7;
	localparam int MR1_RTT_C    = 9;
	localparam int MR1_QOFF     = 12;
	localparam int ADDR_BC_N    = 12;
	// Burst length encodings in bits A1:A0.
	localparam logic [1:0] BL_FIX8   = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam logic [1:0] BL_FIX4   = 2'h2;
	// Bank address codes selecting a mode register.
	localparam logic [2:0] BA_MR0    = 3'h0;
	localparam logic [2:0] BA_MR1    = 3'h1;
	// Register map, byte addresses.
	localparam logic [11:0] OFS_MODE0  = 12'h000;
	localparam logic [11:0] OFS_MODE1  = 12'h004;
	localparam logic [11:0] OFS_CTRL   = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [4:0]  TRP_RESET  = 5'h06;
	// Timing counts.
	localparam logic [2:0] WR_START_BL8   = 3'h6;
	localparam logic [2:0] WR_START_PULL  = 3'h2;
	localparam int         DLL_RST_NS     = 200;
	localparam int         PCLK_NS        = 50;
	localparam logic [3:0] DLL_RST_CYCLES = 4'((DLL_RST_NS + PCLK_NS - 1) / PCLK_NS);
	localparam logic [2:0] LAST_BEAT      = 3'h7;
	localparam logic [2:0] HALF_BEAT      = 3'h4;
	localparam logic [2:0] BEAT_ZERO      = 3'h0;
	localparam logic [2:0] BEAT_ONE       = 3'h1;
endpackage

`timescale 1ns/10ps

// Column index of one beat, given the starting column and the burst type.
module burst_order (
	input  wire logic [2:0] start_col,
	input  wire logic [2:0] beat,
	input  wire logic       interleave,
	input  wire logic       is_write,
	input  wire logic       chop,
	output logic      [2:0] col
);
	logic [1:0] low_sum;

	// Writes ignore the low start bits; reads wrap in the nibble or xor in.
	always_comb begin
		low_sum = start_col[1:0] + beat[1:0];
		if (is_write && chop) begin
			col = {start_col[2], beat[1:0]};
		end else if (is_write) begin
			col = beat;
		end else if (interleave) begin
			col = beat ^ start_col;
		end else begin
			col = {start_col[2] ^ beat[2], low_sum};
		end
	end
endmodule // burst_order

// ---- core/ddr_mode_ctrl.sv ----
// Mode register decode and burst sequencer of the memory device, sampling
// the command and address pins from the controller with the APB clock.
// Assumes pclk at 20 MHz, pins that stay stable around each rising ck edge,
// and an APB master that keeps to the two-phase protocol.
//
// Notes on behaviour
// - Bit A3 of mode register 0 selects sequential or interleaved burst order.
// - Bits A1:A0 pick fixed chop-4, fixed eight, or on-the-fly via A12.
// - Sequential eight-read wraps low bits within a nibble, bit 2 picks nibble.
// - Interleaved eight-read beat i goes to column i xor start column.
// - Chop-4 read gives four beats in one nibble, drivers off afterwards.
// - Chop-4 write stores 0-3 or 4-7 by column bit 2 only.
// - Eight-beat write always stores 0 to 7, ignoring low column bits.
// - Fixed chop-4 starts the internal write two clocks earlier.
// - On-the-fly chop-4 starts the internal write like an eight-beat write.
// - The DLL reset bit clears itself once the reset has been carried out.
// - Write recovery from A11:A9 plus precharge time gives the write-to-activate delay.
// - Slow exit freezes the DLL during precharge power-down.
// - Fast exit keeps the DLL running during precharge power-down.
// - Set command with bank code one loads mode register 1 from address.
// - Mode register 1 holds DLL, driver, termination, latency, leveling, output off.
// - Output disable bit turns off data and strobe drivers.

`timescale 1ns/10ps

module ddr_mode_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ck,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [12:0] addr,
	input  wire logic        pd_active,
	output logic             beat_valid,
	output logic [2:0]       beat_num,
	output logic [2:0]       beat_col,
	output logic             beat_write,
	output logic             beat_drive,
	output logic             beat_store,
	output logic             write_start,
	output logic             dll_frozen
);
	localparam int PW = 22;

	// Three-stage sampling of every pin; a bit settles when stages two and three agree.
	logic [PW-1:0] s1, s2, s3, pins, next_pins;
	logic          ck_d;
	always_comb begin
		next_pins = (s3 & ~(s2 ^ s3)) | (pins & (s2 ^ s3));
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			pins <= '0;
			ck_d <= 1'b0;
		end else begin
			s1   <= {ck, cs_n, ras_n, cas_n, we_n, ba, addr, pd_active};
			s2   <= s1;
			s3   <= s2;
			pins <= next_pins;
			ck_d <= pins[PW-1];
		end
	end

	logic        p_ck, p_cs_n, p_ras_n, p_cas_n, p_we_n, p_pd;
	logic [2:0]  p_ba;
	logic [12:0] p_addr;
	logic        ck_rise, cmd_mrs, cmd_rd, cmd_wr;
	assign {p_ck, p_cs_n, p_ras_n, p_cas_n, p_we_n, p_ba, p_addr, p_pd} = pins;
	// Commands are decoded once per settled rising edge of the link clock.
	assign ck_rise = p_ck & ~ck_d;
	assign cmd_mrs = ck_rise & ~p_cs_n & ~p_ras_n & ~p_cas_n & ~p_we_n;
	assign cmd_rd  = ck_rise & ~p_cs_n & p_ras_n & ~p_cas_n & p_we_n;
	assign cmd_wr  = ck_rise & ~p_cs_n & p_ras_n & ~p_cas_n & ~p_we_n;

	// Mode registers and the DLL reset timer.
	logic [12:0] mr0, mr1, next_mr0, next_mr1;
	logic [3:0]  dll_cnt, next_dll_cnt;
	always_comb begin
		next_mr0     = mr0;
		next_mr1     = mr1;
		next_dll_cnt = dll_cnt;
		if (dll_cnt != 4'h0) begin
			next_dll_cnt = dll_cnt - 4'h1;
			if (dll_cnt == 4'h1) begin
				next_mr0[ddr_mode_pkg::MR0_DLL_RST] = 1'b0;
			end
		end
		// A new set command wins over the self-clear in the same cycle.
		if (cmd_mrs && p_ba == ddr_mode_pkg::BA_MR0) begin
			next_mr0 = p_addr;
			if (p_addr[ddr_mode_pkg::MR0_DLL_RST]) begin
				next_dll_cnt = ddr_mode_pkg::DLL_RST_CYCLES;
			end
		end
		if (cmd_mrs && p_ba == ddr_mode_pkg::BA_MR1) begin
			next_mr1 = p_addr;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mr0     <= '0;
			mr1     <= '0;
			dll_cnt <= 4'h0;
		end else begin
			mr0     <= next_mr0;
			mr1     <= next_mr1;
			dll_cnt <= next_dll_cnt;
		end
	end

	// Burst length choice: fixed, or taken from A12 with the command.
	logic [1:0] bl_mode;
	logic       cmd_chop;
	assign bl_mode  = mr0[ddr_mode_pkg::MR0_BL_HI:ddr_mode_pkg::MR0_BL_LO];
	assign cmd_chop = (bl_mode == ddr_mode_pkg::BL_FIX4) ||
		(bl_mode == ddr_mode_pkg::BL_OTF && !p_addr[ddr_mode_pkg::ADDR_BC_N]);

	// Burst sequencer: one beat per pclk cycle; read and write commands inside a burst are dropped.
	typedef enum logic [0:0] {
		B_IDLE  = 1'b0,
		B_BEATS = 1'b1
	} burst_state_t;
	burst_state_t state, next_state;
	logic [2:0] b_beat, next_b_beat, b_start, next_b_start;
	logic       b_write, next_b_write, b_chop, next_b_chop, b_il, next_b_il;
	always_comb begin
		next_state   = state;
		next_b_beat  = b_beat;
		next_b_start = b_start;
		next_b_write = b_write;
		next_b_chop  = b_chop;
		next_b_il    = b_il;
		case (state)
			B_IDLE: begin
				if (cmd_rd || cmd_wr) begin
					next_state   = B_BEATS;
					next_b_beat  = ddr_mode_pkg::BEAT_ZERO;
					next_b_start = p_addr[2:0];
					next_b_write = cmd_wr;
					next_b_chop  = cmd_chop;
					next_b_il    = mr0[ddr_mode_pkg::MR0_BT];
				end
			end
			B_BEATS: begin
				next_b_beat = b_beat + ddr_mode_pkg::BEAT_ONE;
				if (b_beat == ddr_mode_pkg::LAST_BEAT) begin
					next_state = B_IDLE;
				end
			end
			default: next_state = B_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= B_IDLE;
			b_beat  <= 3'h0;
			b_start <= 3'h0;
			b_write <= 1'b0;
			b_chop  <= 1'b0;
			b_il    <= 1'b0;
		end else begin
			state   <= next_state;
			b_beat  <= next_b_beat;
			b_start <= next_b_start;
			b_write <= next_b_write;
			b_chop  <= next_b_chop;
			b_il    <= next_b_il;
		end
	end

	logic [2:0] order_col;
	burst_order u_order (
		.start_col  (b_start),
		.beat       (b_beat),
		.interleave (b_il),
		.is_write   (b_write),
		.chop       (b_chop),
		.col        (order_col)
	);

	// Beat outputs are registered so the data path sees clean levels.
	logic in_burst, upper_half, next_drive, next_store;
	assign in_burst   = (state == B_BEATS);
	assign upper_half = b_beat >= ddr_mode_pkg::HALF_BEAT;
	always_comb begin
		next_drive = in_burst && !b_write && !(b_chop && upper_half)
			&& !mr1[ddr_mode_pkg::MR1_QOFF];
		next_store = in_burst && b_write && !(b_chop && upper_half);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			beat_valid <= 1'b0;
			beat_num   <= 3'h0;
			beat_col   <= 3'h0;
			beat_write <= 1'b0;
			beat_drive <= 1'b0;
			beat_store <= 1'b0;
		end else begin
			beat_valid <= in_burst;
			beat_num   <= b_beat;
			beat_col   <= order_col;
			beat_write <= b_write;
			beat_drive <= next_drive;
			beat_store <= next_store;
		end
	end

	// Internal write start, counted in link clocks after the write command.
	// Fixed chop-4 pulls it in by two clocks; on-the-fly chop does not.
	logic [2:0] ws_cnt, next_ws_cnt;
	logic       next_write_start;
	always_comb begin
		next_ws_cnt      = ws_cnt;
		next_write_start = 1'b0;
		if (cmd_wr && state == B_IDLE) begin
			if (bl_mode == ddr_mode_pkg::BL_FIX4) begin
				next_ws_cnt = ddr_mode_pkg::WR_START_BL8 - ddr_mode_pkg::WR_START_PULL;
			end else begin
				next_ws_cnt = ddr_mode_pkg::WR_START_BL8;
			end
		end else if (ck_rise && ws_cnt != 3'h0) begin
			next_ws_cnt      = ws_cnt - 3'h1;
			next_write_start = (ws_cnt == 3'h1);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ws_cnt      <= 3'h0;
			write_start <= 1'b0;
		end else begin
			ws_cnt      <= next_ws_cnt;
			write_start <= next_write_start;
		end
	end

	// Write recovery in clocks, and the auto-precharge write-to-activate delay.
	logic [4:0] wr_clk, trp;
	logic [5:0] tdal;
	always_comb begin
		case (mr0[ddr_mode_pkg::MR0_WR_HI:ddr_mode_pkg::MR0_WR_LO])
			3'h1:    wr_clk = 5'h05;
			3'h2:    wr_clk = 5'h06;
			3'h3:    wr_clk = 5'h07;
			3'h4:    wr_clk = 5'h08;
			3'h5:    wr_clk = 5'h0a;
			3'h6:    wr_clk = 5'h0c;
			3'h7:    wr_clk = 5'h0e;
			default: wr_clk = 5'h10;
		endcase
		tdal = {1'b0, wr_clk} + {1'b0, trp};
	end

	// The DLL freezes in power-down only under slow exit and while it is enabled.
	logic next_frozen;
	assign next_frozen = p_pd && !mr0[ddr_mode_pkg::MR0_PPD]
		&& !mr1[ddr_mode_pkg::MR1_DLL_DIS];

	// APB slave: zero wait states, read data captured in the setup phase.
	logic        setup, access, hit, next_err;
	logic [31:0] next_rdata;
	logic [4:0]  next_trp;
	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign pready = 1'b1;
	always_comb begin
		hit        = 1'b1;
		next_rdata = 32'h0;
		case (paddr)
			ddr_mode_pkg::OFS_MODE0:  next_rdata = {19'h0, mr0};
			ddr_mode_pkg::OFS_MODE1:  next_rdata = {19'h0, mr1};
			ddr_mode_pkg::OFS_CTRL:   next_rdata = {27'h0, trp};
			ddr_mode_pkg::OFS_STATUS: next_rdata = {18'h0, dll_frozen, in_burst,
				dll_cnt != 4'h0, tdal, wr_clk};
			default:                  hit = 1'b0;
		endcase
		next_err = setup && !hit;
		next_trp = trp;
		if (access && pwrite && paddr == ddr_mode_pkg::OFS_CTRL) begin
			next_trp = pwdata[4:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h0;
			pslverr    <= 1'b0;
			trp        <= ddr_mode_pkg::TRP_RESET;
			dll_frozen <= 1'b0;
		end else begin
			if (setup) begin
				prdata  <= pwrite ? 32'h0 : next_rdata;
				pslverr <= next_err;
			end
			trp        <= next_trp;
			dll_frozen <= next_frozen;
		end
	end

	// Checks on the beat order, the mode registers and the write start.
	AST_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
		beat_valid && !beat_write && !$past(b_il) |->
		beat_col == {$past(b_start[2]) ^ beat_num[2], 2'($past(b_start[1:0]) + beat_num[1:0])})
		else $error("sequential read column wrong");
	AST_INTLV: assert property (@(posedge pclk) disable iff (!presetn)
		beat_valid && !beat_write && $past(b_il) |-> beat_col == (beat_num ^ $past(b_start)))
		else $error("interleaved read column wrong");
	AST_CHOP_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
		beat_valid && !beat_write && $past(b_chop) && beat_num[2] |-> !beat_drive)
		else $error("chop read drives upper half");
	AST_WR8: assert property (@(posedge pclk) disable iff (!presetn)
		beat_valid && beat_write && !$past(b_chop) |-> beat_col == beat_num && beat_store)
		else $error("eight-beat write out of order");
	AST_BC4W: assert property (@(posedge pclk) disable iff (!presetn)
		beat_valid && beat_write && $past(b_chop) |->
		beat_col == {$past(b_start[2]), beat_num[1:0]} && beat_store == !beat_num[2])
		else $error("chop write order wrong");
	AST_QOFF: assert property (@(posedge pclk) disable iff (!presetn)
		$past(mr1[ddr_mode_pkg::MR1_QOFF]) |-> !beat_drive)
		else $error("drivers on while outputs disabled");
	AST_DLLCLR: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mr0[ddr_mode_pkg::MR0_DLL_RST]) |-> ##[1:6] !mr0[ddr_mode_pkg::MR0_DLL_RST])
		else $error("DLL reset bit did not clear");
	AST_MR1LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_mrs && p_ba == ddr_mode_pkg::BA_MR1 |=> mr1 == $past(p_addr))
		else $error("mode register 1 not loaded");
	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(cmd_mrs) |-> $stable(mr1))
		else $error("mode register 1 changed without a set command");
	AST_OTF: assert property (@(posedge pclk) disable iff (!presetn)
		(cmd_rd || cmd_wr) && state == B_IDLE && bl_mode == ddr_mode_pkg::BL_OTF
		|=> b_chop == !$past(p_addr[ddr_mode_pkg::ADDR_BC_N]))
		else $error("on-the-fly chop decode wrong");
	AST_WSTART: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_wr && state == B_IDLE && bl_mode == ddr_mode_pkg::BL_FIX4 |=> ws_cnt == 3'h4)
		else $error("fixed chop write start not pulled in");
endmodule // ddr_mode_ctrl

// ---- tb/mem_ctrl_model.sv ----
// Controller-side model: drives the command pins and a gated link clock.
// Assumes the device samples the pins on rising ck edges only.
`timescale 1ns/10ps
module mem_ctrl_model (
	output logic        ck,
	output logic        cs_n,
	output logic        ras_n,
	output logic        cas_n,
	output logic        we_n,
	output logic [2:0]  ba,
	output logic [12:0] addr
);
	int rises = 0;

	// The clock rests low between frames and the bus starts deselected.
	initial begin
		ck = 1'b0;
		{cs_n, ras_n, cas_n, we_n, ba, addr} = '1;
	end

	// One frame: pins move while ck is low, then one 400 ns ck period.
	task automatic cyc(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a);
		// Frame edges fall on pclk edges, so non-blocking updates keep the
		// pins from racing the device's first sampling stage.
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		#200 ck <= 1'b1;
		rises++;
		#200 ck <= 1'b0;
	endtask

	// Deselected frames; the stale address is inverted so it never looks valid.
	task automatic idle(input int n);
		repeat (n) cyc(4'hf, ~ba, ~addr);
	endtask

	// The whole register value goes out every time, reserved bits as given.
	task automatic mrs(input logic [2:0] b, input logic [12:0] v);
		cyc(4'h0, b, v);
		idle(2);
	endtask

	// Read or write command; A12 carries the chop choice.
	task automatic access(input logic w, input logic [12:0] a);
		cyc({2'b01, 1'b0, ~w}, 3'h0, a);
	endtask
endmodule // mem_ctrl_model

// ---- tb/tb_ddr_mode_ctrl.sv ----
// Self-checking bench for the mode register decode and burst sequencer.
// Assumes the controller model drives the pins and this module drives APB.
`timescale 1ns/10ps
module tb_ddr_mode_ctrl;
	localparam logic [11:0] M0 = ddr_mode_pkg::OFS_MODE0;
	localparam logic [11:0] M1 = ddr_mode_pkg::OFS_MODE1;
	localparam logic [11:0] CT = ddr_mode_pkg::OFS_CTRL;
	localparam logic [11:0] ST = ddr_mode_pkg::OFS_STATUS;
	localparam logic [2:0]  B0 = ddr_mode_pkg::BA_MR0;
	localparam logic [2:0]  B1 = ddr_mode_pkg::BA_MR1;
	logic        pclk, presetn, psel, penable, pwrite, pd_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, ck, cs_n, ras_n, cas_n, we_n;
	logic [2:0]  ba, beat_num, beat_col;
	logic [12:0] addr;
	logic        beat_valid, beat_write, beat_drive, beat_store, write_start, dll_frozen;
	logic [2:0]  cols [8];
	logic        drv [8], sto [8], bwr [8];
	int          nbeat = 0, ws_rise = 0, error_cnt = 0, n_tests = 0, trp = 6;
	int          wrt [8] = '{16, 5, 6, 7, 8, 10, 12, 14};

	mem_ctrl_model ctl (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
	ddr_mode_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .pd_active,
		.beat_valid, .beat_num, .beat_col, .beat_write, .beat_drive, .beat_store,
		.write_start, .dll_frozen);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Beats are filed by index, so an order fault shows as a wrong column.
	always @(posedge pclk) begin
		if (beat_valid === 1'b1) begin
			cols[beat_num] <= beat_col;
			drv[beat_num] <= beat_drive;
			sto[beat_num] <= beat_store;
			bwr[beat_num] <= beat_write;
			nbeat <= nbeat + 1;
		end
		if (write_start === 1'b1) ws_rise <= ctl.rises;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("Mismatches %0d, compares %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// One transfer; the request holds until pready is seen high at an edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge pclk);
		end
		if (n == 16) begin
			error_cnt++;
			$display("Error at %0t: no pready", $time);
			print_verdict;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic e;
		apb(1'b0, a, 32'h0, e);
		chk(q, exp, what);
		chk(32'(e), 32'h0, what);
	endtask

	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
		chk(32'(e), 32'h0, "write error flag");
	endtask

	// Reset values, a read-only write and an unmapped word.
	task automatic t_regs;
		logic e;
		rd(M0, 32'h0, "mode0 reset");
		rd(CT, 32'(ddr_mode_pkg::TRP_RESET), "ctrl reset");
		rd(ST, 32'h2d0, "status reset");
		wreg(CT, 32'h3);
		trp = 3;
		wreg(M0, 32'h1fff);
		rd(M0, 32'h0, "mode0 read only");
		apb(1'b0, 12'h010, 32'h0, e);
		chk(32'(e), 32'h1, "unmapped error");
		chk(q, 32'h0, "unmapped data");
	endtask

	// Every write recovery code, with the precharge count added on.
	task automatic t_wr;
		for (int k = 0; k < 8; k++) begin
			ctl.mrs(B0, 13'(k << 9));
			rd(M0, 32'(k << 9), "mode0 wr field");
			rd(ST, 32'(wrt[k] + ((wrt[k] + trp) << 5)), "wr and tdal");
		end
	endtask

	// One access; each filed beat outside a chop's upper half is judged against the order worked out here.
	task automatic burst(input logic w, input logic [2:0] c, input logic bt, input logic ch,
		input logic a12, input logic off);
		int base;
		logic [2:0] e;
		base = nbeat;
		ctl.access(w, {a12, 9'h0, c});
		ctl.idle(2);
		chk(32'(nbeat - base), 32'h8, "beat count");
		for (int i = 0; i < 8; i++) begin
			if (w) e = ch ? {c[2], 2'(i)} : 3'(i);
			else e = bt ? 3'(i) ^ c : {c[2] ^ i[2], c[1:0] + 2'(i)};
			if (!(ch && i > 3)) chk(32'(cols[i]), 32'(e), "beat column");
			chk(32'(drv[i]), 32'(!w && !off && !(ch && i > 3)), "driver on");
			chk(32'(sto[i]), 32'(w && !(ch && i > 3)), "beat stored");
			chk(32'(bwr[i]), 32'(w), "write flag");
		end
	endtask

	// All length codes, both orders, every start column, reads and writes.
	task automatic t_bursts;
		logic [1:0] blc [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
		logic       a12 [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic       ch;
		for (int m = 0; m < 5; m++) begin
			ch = (blc[m] == 2'h1 && !a12[m]) || blc[m] == 2'h2;
			for (int b = 0; b < 2; b++) begin
				ctl.mrs(B0, {9'h0, b[0], 1'b0, blc[m]});
				for (int c = 0; c < 16; c++) burst(c[0], 3'(c >> 1), b[0], ch, a12[m], 1'b0);
			end
		end
	endtask

	// Dll reset clears itself; other mode registers and banks leave fields alone.
	task automatic t_mr;
		// Code four gives eight recovery clocks, above what the bench's memory needs.
		ctl.mrs(B0, 13'h0908);
		ctl.idle(4);
		rd(M0, 32'h808, "dll reset cleared");
		ctl.mrs(B1, 13'h0086);
		rd(M1, 32'h86, "mode1 load");
		rd(M0, 32'h808, "mode0 kept");
		ctl.mrs(3'h2, 13'h0000);
		rd(M1, 32'h86, "other bank ignored");
		rd(M0, 32'h808, "other bank mode0 kept");
		ctl.mrs(B1, 13'h1086);
		burst(1'b0, 3'h5, 1'b1, 1'b0, 1'b0, 1'b1);
		ctl.mrs(B1, 13'h0000);
	endtask

	// Count link clock rises from the write command to the internal start.
	task automatic t_ws(input logic [1:0] bl, input logic a12, input int exp);
		int r0;
		ctl.mrs(B0, {11'h0, bl});
		r0 = ctl.rises;
		ctl.access(1'b1, {a12, 12'h003});
		ctl.idle(8);
		chk(32'(ws_rise - r0), 32'(exp), "write start");
	endtask

	task automatic t_pd(input logic [12:0] v, input logic exp);
		ctl.mrs(B0, v);
		@(posedge pclk);
		pd_active <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(32'(dll_frozen), 32'(exp), "dll frozen");
		pd_active <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'(dll_frozen), 32'h0, "dll resumes");
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, pd_active} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_regs;
		t_wr;
		t_mr;
		t_bursts;
		t_ws(2'h0, 1'b1, 7);
		t_ws(2'h1, 1'b0, 7);
		t_ws(2'h2, 1'b1, 5);
		t_pd(13'h0000, 1'b1);
		t_pd(13'h1000, 1'b0);
		print_verdict;
	end

	// A hang ends the run through the same closing report.
	initial begin
		#2_000_000;
		error_cnt++;
		$display("Error at %0t: run did not finish", $time);
		print_verdict;
	end
endmodule // tb_ddr_mode_ctrl
